// ==== core/iiaux_analog_sel.sv ====
// Analog channel selection and result register
`default_nettype none
module iiaux_analog_sel #(
	parameter int RES = iiaux_pkg::AN_RES_STD
) (
	input wire logic mclk,
	input wire logic nrst,
	input wire logic [iiaux_pkg::AN_CHANNELS*16-1:0] anSamples,
	input wire logic anReq,
	input wire logic [3:0] anChannel,
	output logic [15:0] anValue,
	output logic anValid,
	output logic anError
);
	if (RES != iiaux_pkg::AN_RES_STD && RES != iiaux_pkg::AN_RES_OPT) begin : gBadRes
		$error("Unsupported resolution");
	end
	logic [15:0] next_anValue;
	logic next_anValid;
	logic next_anError;
	logic [3:0] idx;
	always_comb begin
		idx = anChannel - 4'(iiaux_pkg::AN_FIRST);
		next_anValue = anValue;
		next_anValid = 1'b0;
		next_anError = 1'b0;
		if (anReq) begin
			if (anChannel >= 4'(iiaux_pkg::AN_FIRST) && anChannel <= 4'(iiaux_pkg::AN_CHANNELS)) begin
				next_anValue = anSamples[idx[2:0]*16 +: 16] & ~((16'hffff) >> RES);
				next_anValid = 1'b1;
			end else begin
				next_anError = 1'b1;
			end
		end
	end
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			anValue <= 16'h0000;
			anValid <= 1'b0;
			anError <= 1'b0;
		end else begin
			anValue <= next_anValue;
			anValid <= next_anValid;
			anError <= next_anError;
		end
	end
	anValid_error_a: assert property (@(posedge mclk) disable iff (!nrst)
		anReq |=> anValid != anError) else $error("Valid and error together");
endmodule : iiaux_analog_sel
`default_nettype wire

// ==== core/iiaux_input_irq.sv ====
// Input interrupt, auxiliary inputs, level query and extended I/O
`default_nettype none
module iiaux_input_irq #(
	parameter int AXES = 8,
	parameter int PC_W = 16,
	parameter int AN_RES = iiaux_pkg::AN_RES_STD
) (
	input wire logic mclk,
	input wire logic nrst,
	input wire logic [15:0] genIn,
	input wire logic [AXES-1:0] auxChanA,
	input wire logic [AXES-1:0] auxChanB,
	input wire logic [AXES-1:0] axisStepper,
	input wire logic [63:0] extIn,
	input wire logic [7:0] extDirWr,
	input wire logic extDirWrEn,
	input wire logic [63:0] extOutWr,
	input wire logic extOutWrEn,
	input wire logic irqEnableCmd,
	input wire logic irqRangeGiven,
	input wire logic [6:0] irqFirst,
	input wire logic [6:0] irqLast,
	input wire logic [95:0] irqMask,
	input wire logic [PC_W-1:0] curPc,
	input wire logic [PC_W-1:0] serviceAddr,
	input wire logic irqReturnInstr,
	input wire logic returnStackClearInstr,
	input wire logic queryReq,
	input wire logic [6:0] queryIndex,
	input wire logic [iiaux_pkg::AN_CHANNELS*16-1:0] anSamples,
	input wire logic anReq,
	input wire logic [3:0] anChannel,
	output logic [63:0] extOut,
	output logic [7:0] extDir,
	output logic queryLevel,
	output logic queryValid,
	output logic queryError,
	output logic pcLoad,
	output logic [PC_W-1:0] pcTarget,
	output logic inService,
	output logic [95:0] irqEnabled,
	output logic [15:0] anValue,
	output logic anValid,
	output logic anError
);
	if (AXES < 1 || AXES > 8) begin : gBadAxes
		$error("AXES must be 1 to 8");
	end
	if (PC_W < 1) begin : gBadPc
		$error("PC_W must be positive");
	end

	function automatic logic validIdx(input logic [6:0] n);
		validIdx = n >= 7'h01 && n <= 7'(iiaux_pkg::NUM_INPUTS);
	endfunction : validIdx

	// Live level and availability of general inputs 1 to 16, bit k is input k+1; bits above 15 stay zero here
	logic [95:0] level;
	logic [95:0] avail;
	always_comb begin
		level = '0;
		avail = '0;
		level[15:0] = genIn;
		avail[15:0] = 16'hffff;
	end
	logic [63:0] extLevel;
	logic [31:0] auxLevel;
	logic [31:0] auxAvail;
	genvar g;
	generate
		for (g = 0; g < iiaux_pkg::EXT_BLOCKS; g++) begin : gExt
			assign extLevel[g*8 +: 8] = extDir[g] ? extOut[g*8 +: 8] : extIn[g*8 +: 8];
		end
		for (g = 0; g < 16; g++) begin : gAux
			if (g < AXES) begin : gOn
				assign auxLevel[2*g] = auxChanA[g];
				assign auxLevel[2*g+1] = auxChanB[g];
				assign auxAvail[2*g +: 2] = {2{~axisStepper[g]}};
			end else begin : gOff
				assign auxLevel[2*g +: 2] = 2'b11;
				assign auxAvail[2*g +: 2] = 2'b00;
			end
		end
	endgenerate
	logic [95:0] allLevel;
	logic [95:0] allAvail;
	assign allLevel = {auxLevel[15:0], extLevel, level[15:0]};
	assign allAvail = {auxAvail[15:0], 64'hffffffffffffffff, avail[15:0]};

	// Extended I/O direction and output latches
	logic [7:0] next_extDir;
	logic [63:0] next_extOut;
	always_comb begin
		next_extDir = extDirWrEn ? extDirWr : extDir;
		next_extOut = extOut;
		for (int b = 0; b < iiaux_pkg::EXT_BLOCKS; b++) begin
			if (extOutWrEn && next_extDir[b]) next_extOut[b*8 +: 8] = extOutWr[b*8 +: 8];
		end
	end

	// Level query
	logic next_queryLevel;
	logic next_queryValid;
	logic next_queryError;
	logic [6:0] qi;
	always_comb begin
		qi = queryIndex - 7'h01;
		next_queryLevel = queryLevel;
		next_queryValid = 1'b0;
		next_queryError = 1'b0;
		if (queryReq) begin
			if (validIdx(queryIndex) && allAvail[qi]) begin
				next_queryLevel = allLevel[qi];
				next_queryValid = 1'b1;
			end else begin
				next_queryError = 1'b1;
			end
		end
	end

	// Enable set
	logic [95:0] next_irqEnabled;
	always_comb begin
		next_irqEnabled = irqEnabled;
		if (irqEnableCmd) begin
			if (irqRangeGiven) begin
				for (int k = 0; k < iiaux_pkg::NUM_INPUTS; k++) begin
					next_irqEnabled[k] = 7'(k + 1) >= irqFirst && 7'(k + 1) <= irqLast;
				end
			end else begin
				next_irqEnabled = irqMask;
			end
		end
	end

	// Sequencer diversion
	iiaux_pkg::iiaux_state_e state;
	iiaux_pkg::iiaux_state_e next_state;
	logic [PC_W-1:0] retPc;
	logic [PC_W-1:0] next_retPc;
	logic next_pcLoad;
	logic [PC_W-1:0] next_pcTarget;
	logic trigger;
	assign trigger = |(irqEnabled & allAvail & ~allLevel);
	always_comb begin
		next_state = state;
		next_retPc = retPc;
		next_pcLoad = 1'b0;
		next_pcTarget = pcTarget;
		case (state)
			iiaux_pkg::IIAUX_RUN: begin
				if (trigger) begin
					next_retPc = curPc;
					next_pcLoad = 1'b1;
					next_pcTarget = serviceAddr;
					next_state = iiaux_pkg::IIAUX_SERVICE;
				end
			end
			iiaux_pkg::IIAUX_SERVICE: begin
				if (irqReturnInstr) begin
					next_pcLoad = 1'b1;
					next_pcTarget = retPc;
					next_state = iiaux_pkg::IIAUX_RUN;
				end else if (returnStackClearInstr) begin
					next_state = iiaux_pkg::IIAUX_DETACHED;
				end
			end
			iiaux_pkg::IIAUX_DETACHED: begin
				if (irqReturnInstr) next_state = iiaux_pkg::IIAUX_RUN;
			end
			default: next_state = iiaux_pkg::IIAUX_RUN;
		endcase
	end

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			extDir <= 8'h00;
			extOut <= 64'h0000000000000000;
			queryLevel <= 1'b0;
			queryValid <= 1'b0;
			queryError <= 1'b0;
			irqEnabled <= 96'h0;
			state <= iiaux_pkg::IIAUX_RUN;
			retPc <= '0;
			pcLoad <= 1'b0;
			pcTarget <= '0;
			inService <= 1'b0;
		end else begin
			extDir <= next_extDir;
			extOut <= next_extOut;
			queryLevel <= next_queryLevel;
			queryValid <= next_queryValid;
			queryError <= next_queryError;
			irqEnabled <= next_irqEnabled;
			state <= next_state;
			retPc <= next_retPc;
			pcLoad <= next_pcLoad;
			pcTarget <= next_pcTarget;
			inService <= next_state != iiaux_pkg::IIAUX_RUN;
		end
	end

	iiaux_analog_sel #(.RES(AN_RES)) uAnalog (
		.mclk(mclk),
		.nrst(nrst),
		.anSamples(anSamples),
		.anReq(anReq),
		.anChannel(anChannel),
		.anValue(anValue),
		.anValid(anValid),
		.anError(anError)
	);

	irq_take_a: assert property (@(posedge mclk) disable iff (!nrst)
		(state == iiaux_pkg::IIAUX_RUN && trigger) |=> pcLoad && pcTarget == $past(serviceAddr)) else $error("No jump");
	irq_return_a: assert property (@(posedge mclk) disable iff (!nrst)
		(state == iiaux_pkg::IIAUX_SERVICE && irqReturnInstr) |=> pcLoad && pcTarget == $past(retPc)) else $error("Bad return");
	no_reenter_a: assert property (@(posedge mclk) disable iff (!nrst)
		(state != iiaux_pkg::IIAUX_RUN && !irqReturnInstr) |=> !pcLoad)
		else $error("Re-entered");
	stack_clear_a: assert property (@(posedge mclk) disable iff (!nrst)
		(state == iiaux_pkg::IIAUX_SERVICE && returnStackClearInstr && !irqReturnInstr) |=> !pcLoad && inService)
		else $error("Stack clear failed");
	range_en_a: assert property (@(posedge mclk) disable iff (!nrst)
		(irqEnableCmd && irqRangeGiven && validIdx(irqFirst) && irqFirst <= irqLast) |=> irqEnabled[$past(irqFirst) - 7'h01])
		else $error("Range not enabled");
	mask_en_a: assert property (@(posedge mclk) disable iff (!nrst)
		(irqEnableCmd && !irqRangeGiven) |=> irqEnabled == $past(irqMask)) else $error("Mask not loaded");
	query_a: assert property (@(posedge mclk) disable iff (!nrst)
		(queryReq && !validIdx(queryIndex)) |=> queryError && !queryValid) else $error("Bad index accepted");
	stepper_a: assert property (@(posedge mclk) disable iff (!nrst)
		(queryReq && queryIndex == iiaux_pkg::AUX_FIRST && axisStepper[0]) |=> queryError) else $error("Stepper aux read");
	aux_map_a: assert property (@(posedge mclk) disable iff (!nrst)
		(queryReq && queryIndex == iiaux_pkg::AUX_FIRST && !axisStepper[0]) |=> queryLevel == $past(auxChanA[0]))
		else $error("Aux map wrong");
	ext_dir_a: assert property (@(posedge mclk) disable iff (!nrst)
		extDirWrEn |=> extDir == $past(extDirWr)) else $error("Direction not set");
	take_c: cover property (@(posedge mclk) disable iff (!nrst) state == iiaux_pkg::IIAUX_RUN && trigger);
	ret_c: cover property (@(posedge mclk) disable iff (!nrst) state == iiaux_pkg::IIAUX_SERVICE && irqReturnInstr);
	clear_c: cover property (@(posedge mclk) disable iff (!nrst) state == iiaux_pkg::IIAUX_DETACHED);
	query_c: cover property (@(posedge mclk) disable iff (!nrst) queryValid);
endmodule : iiaux_input_irq
`default_nettype wire

// ==== core/iiaux_pkg.sv ====
// Constants for the input interrupt and auxiliary input block
`default_nettype none
package iiaux_pkg;
	localparam int NUM_INPUTS = 96;
	localparam int IDX_W = 7;
	localparam logic [6:0] AUX_FIRST = 7'h51;
	localparam logic [6:0] EXT_FIRST = 7'h11;
	localparam logic [6:0] EXT_LAST = 7'h50;
	localparam int EXT_BLOCKS = 8;
	localparam int BLOCK_BITS = 8;
	localparam int AN_CHANNELS = 8;
	localparam int AN_RES_STD = 12;
	localparam int AN_RES_OPT = 16;
	localparam logic [2:0] AN_FIRST = 3'h1;
	typedef enum logic [2:0] {
		IIAUX_RUN = 3'h1,
		IIAUX_SERVICE = 3'h2,
		IIAUX_DETACHED = 3'h4
	} iiaux_state_e;
endpackage : iiaux_pkg
`default_nettype wire

// ==== verification/iiaux_sensor_model.sv ====
// Field switches and sensors driving the block inputs
`default_nettype none
module iiaux_sensor_model (
	input wire logic [95:0] levels,
	output logic [15:0] genIn,
	output logic [7:0] auxChanA,
	output logic [7:0] auxChanB,
	output logic [63:0] extIn,
	output logic [127:0] anSamples
);
	timeunit 1ns;
	timeprecision 1ps;
	always_comb begin
		genIn = levels[15:0];
		extIn = levels[79:16];
		for (int k = 0; k < 8; k++) begin
			auxChanA[k] = levels[80+2*k];
			auxChanB[k] = levels[81+2*k];
			anSamples[k*16+:16] = 16'h1357 + 16'h1111 * k[15:0];
		end
	end
endmodule : iiaux_sensor_model
`default_nettype wire

// ==== verification/input_interrupt_aux_inputs_tb.sv ====
// Self-checking bench for the input interrupt block
`default_nettype none
module input_interrupt_aux_inputs_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic mclk, nrst, extDirWrEn, extOutWrEn, irqEnableCmd, irqRangeGiven;
	logic irqReturnInstr, returnStackClearInstr, queryReq, anReq;
	logic queryLevel, queryValid, queryError, pcLoad, inService, anValid, anError;
	logic [95:0] lvl, irqMask, irqEnabled;
	logic [15:0] genIn, curPc, serviceAddr, pcTarget, anValue;
	logic [7:0] auxChanA, auxChanB, axisStepper, extDirWr, extDir;
	logic [63:0] extIn, extOutWr, extOut;
	logic [127:0] anSamples;
	logic [6:0] irqFirst, irqLast, queryIndex;
	logic [3:0] anChannel;
	int fails = 0;
	int checks_done = 0;
	iiaux_sensor_model field (.levels(lvl), .genIn(genIn), .auxChanA(auxChanA), .auxChanB(auxChanB),
		.extIn(extIn), .anSamples(anSamples));
	iiaux_input_irq uut (.mclk(mclk), .nrst(nrst), .genIn(genIn), .auxChanA(auxChanA), .auxChanB(auxChanB),
		.axisStepper(axisStepper), .extIn(extIn), .extDirWr(extDirWr), .extDirWrEn(extDirWrEn),
		.extOutWr(extOutWr), .extOutWrEn(extOutWrEn), .irqEnableCmd(irqEnableCmd),
		.irqRangeGiven(irqRangeGiven), .irqFirst(irqFirst), .irqLast(irqLast), .irqMask(irqMask),
		.curPc(curPc), .serviceAddr(serviceAddr), .irqReturnInstr(irqReturnInstr),
		.returnStackClearInstr(returnStackClearInstr), .queryReq(queryReq), .queryIndex(queryIndex),
		.anSamples(anSamples), .anReq(anReq), .anChannel(anChannel), .extOut(extOut), .extDir(extDir),
		.queryLevel(queryLevel), .queryValid(queryValid), .queryError(queryError), .pcLoad(pcLoad),
		.pcTarget(pcTarget), .inService(inService), .irqEnabled(irqEnabled), .anValue(anValue),
		.anValid(anValid), .anError(anError));
	task automatic chk(input string nm, input logic [95:0] got, input logic [95:0] exp);
		checks_done++;
		if (got !== exp) begin
			fails++;
			$display("ERROR %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk
	task automatic conclude();
		$display("checks %0d mismatches %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : conclude
	task automatic q(input logic [6:0] i, input logic e, input logic lv);
		@(negedge mclk);
		queryIndex = i;
		queryReq = 1'b1;
		@(negedge mclk);
		queryReq = 1'b0;
		chk("qerr", queryError, e);
		chk("qvalid", queryValid, !e);
		if (!e)
			chk("qlevel", queryLevel, lv);
	endtask : q
	task automatic en(input logic rg, input logic [6:0] f, input logic [6:0] l, input logic [95:0] m);
		@(negedge mclk);
		irqRangeGiven = rg;
		irqFirst = f;
		irqLast = l;
		irqMask = m;
		irqEnableCmd = 1'b1;
		@(negedge mclk);
		irqEnableCmd = 1'b0;
	endtask : en
	task automatic query_inputs();
		lvl[80] = 1'b0;
		lvl[95] = 1'b0;
		q(7'h51, 1'b0, 1'b0);
		q(7'h52, 1'b0, 1'b1);
		q(7'h60, 1'b0, 1'b0);
		q(7'h01, 1'b0, 1'b1);
		q(7'h00, 1'b1, 1'b0);
		q(7'h61, 1'b1, 1'b0);
		axisStepper = 8'h80;
		q(7'h5f, 1'b1, 1'b0);
		q(7'h5d, 1'b0, 1'b1);
		axisStepper = 8'h00;
		lvl = '1;
	endtask : query_inputs
	task automatic enables();
		en(1'b1, 7'h03, 7'h05, 96'hffff);
		chk("rng", irqEnabled, 96'h1c);
		en(1'b1, 7'h51, 7'h60, 96'h0);
		chk("rnghi", irqEnabled, {16'hffff, 80'h0});
		en(1'b0, 7'h00, 7'h00, 96'h5);
		chk("mask", irqEnabled, 96'h5);
	endtask : enables
	task automatic irq_return();
		en(1'b0, 7'h00, 7'h00, 96'h1);
		curPc = 16'h1234;
		serviceAddr = 16'h0400;
		lvl[0] = 1'b0;
		@(negedge mclk);
		chk("jump", {pcLoad, inService, pcTarget}, {2'b11, 16'h0400});
		curPc = 16'h5555;
		repeat (3) begin
			@(negedge mclk);
			chk("retrig", pcLoad, 1'b0);
		end
		lvl[0] = 1'b1;
		irqReturnInstr = 1'b1;
		@(negedge mclk);
		irqReturnInstr = 1'b0;
		chk("ret", {pcLoad, inService, pcTarget}, {2'b10, 16'h1234});
	endtask : irq_return
	task automatic stack_clear();
		lvl[0] = 1'b0;
		@(negedge mclk);
		chk("jump2", {pcLoad, inService}, 2'b11);
		lvl[0] = 1'b1;
		returnStackClearInstr = 1'b1;
		@(negedge mclk);
		returnStackClearInstr = 1'b0;
		chk("clr", {pcLoad, inService}, 2'b01);
		irqReturnInstr = 1'b1;
		@(negedge mclk);
		irqReturnInstr = 1'b0;
		chk("clrret", {pcLoad, inService}, 2'b00);
	endtask : stack_clear
	task automatic analog();
		for (int c = 0; c < 10; c++) begin
			@(negedge mclk);
			anChannel = c[3:0];
			anReq = 1'b1;
			@(negedge mclk);
			anReq = 1'b0;
			chk("anerr", anError, c == 0 || c == 9);
			chk("anvalid", anValid, !(c == 0 || c == 9));
			if (c > 0 && c < 9)
				chk("anval", anValue, (16'h1357 + 16'h1111 * c[15:0] - 16'h1111) & 16'hfff0);
		end
	endtask : analog
	task automatic ext_io();
		@(negedge mclk);
		extDirWr = 8'h01;
		extDirWrEn = 1'b1;
		@(negedge mclk);
		extDirWrEn = 1'b0;
		extOutWr = 64'hffff_ffff_ffff_ffa5;
		extOutWrEn = 1'b1;
		@(negedge mclk);
		extOutWrEn = 1'b0;
		chk("dir", extDir, 8'h01);
		chk("out", extOut, 64'ha5);
		q(7'h11, 1'b0, 1'b1);
		q(7'h12, 1'b0, 1'b0);
		q(7'h19, 1'b0, 1'b1);
	endtask : ext_io
	initial begin
		mclk = 1'b0;
		forever #4 mclk = ~mclk;
	end
	initial begin
		#400000;
		fails++;
		conclude();
	end
	initial begin
		{nrst, extDirWrEn, extOutWrEn, irqEnableCmd, irqRangeGiven, irqReturnInstr} = '0;
		{returnStackClearInstr, queryReq, anReq, irqMask, curPc, serviceAddr} = '0;
		{axisStepper, extDirWr, extOutWr, irqFirst, irqLast, queryIndex, anChannel} = '0;
		lvl = '1;
		repeat (12) @(negedge mclk);
		nrst = 1'b1;
		query_inputs();
		enables();
		irq_return();
		stack_clear();
		analog();
		ext_io();
		conclude();
	end
endmodule : input_interrupt_aux_inputs_tb
`default_nettype wire
